// [verilog/qfr_pkg.sv]
// Purpose: Constants for the quad-lane word fast read responder.
// Assumes: Serial clock is sampled by ref_clk_i (125 MHz).
// Notes: Encodings and phase lengths of the link.
package qfr_pkg;
    localparam logic [7:0] CMD_WORD_READ   = 8'he7;
    localparam logic [3:0] CONT_NIBBLE     = 4'ha;
    localparam logic [2:0] CMD_LAST_EDGE   = 3'h7;
    localparam logic [2:0] ADDR_LAST_EDGE  = 3'h5;
    localparam logic [2:0] MODE_LAST_EDGE  = 3'h1;
    localparam logic [2:0] DUMMY_LAST_EDGE = 3'h1;
    localparam int         ADDR_W          = 24;
    localparam int         MEM_AW          = 10;
    localparam int         MEM_DEPTH       = 1 << MEM_AW;
    localparam int         SYNC_W          = 6;
    localparam int         SY_SCK          = 0;
    localparam int         SY_CSN          = 1;
    localparam int         SY_D0           = 2;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CMD,
        ST_ADDR,
        ST_MODE,
        ST_DUMMY,
        ST_DATA,
        ST_IGNORE
    } qfr_state_type;
endpackage

// [verilog/qfr_flash_reader.sv]
// Purpose: Flash-side responder for the quad-lane word fast read.
// Assumes: Link clock and select are slow enough to be oversampled.
// Notes: Contents are loaded from the user-side write port.
`timescale 1ns/10ps
module qfr_flash_reader (
    input  wire logic                       ref_clk_i,
    input  wire logic                       arst_n_i,
    input  wire logic                       flash_chip_select_n_i,
    input  wire logic                       flash_serial_clock_i,
    input  wire logic                       flash_data_line0_i,
    input  wire logic                       flash_data_line1_i,
    input  wire logic                       flash_data_line2_i,
    input  wire logic                       flash_data_line3_i,
    output logic                            flash_data_line0_o,
    output logic                            flash_data_line1_o,
    output logic                            flash_data_line2_o,
    output logic                            flash_data_line3_o,
    output logic                            flash_data_line0_oe_o,
    output logic                            flash_data_line1_oe_o,
    output logic                            flash_data_line2_oe_o,
    output logic                            flash_data_line3_oe_o,
    input  wire logic                       load_valid_i,
    input  wire logic [qfr_pkg::MEM_AW-1:0] load_addr_i,
    input  wire logic [7:0]                 load_data_i,
    output logic                            continuous_mode_o
);
    import qfr_pkg::*;

    // Select idles high, so the synchroniser leaves reset showing no frame.
    localparam logic [SYNC_W-1:0] SYNC_IDLE = SYNC_W'(1) << SY_CSN;

    logic [SYNC_W-1:0]     in_meta;
    logic [SYNC_W-1:0]     in_sync;
    logic                  sck_prev;
    logic                  sck_rise;
    logic                  sck_fall;
    logic                  cs_high;
    logic [3:0]            lanes_in;
    qfr_state_type         state;
    logic [2:0]            edge_cnt;
    logic [7:0]            byte_shift;
    logic [ADDR_W-1:0]     read_start_address;
    logic [7:0]            continuous_mode_bits;
    logic                  cont_mode;
    logic                  low_nibble;
    logic [3:0]            lane_out;
    logic                  lane_oe;
    logic [7:0]            mem [0:MEM_DEPTH-1];
    logic [7:0]            mem_byte;

    // Select, clock and the four lanes are resynchronised before use.
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            in_meta <= SYNC_IDLE;
            in_sync <= SYNC_IDLE;
        end else begin
            in_meta <= {flash_data_line3_i, flash_data_line2_i, flash_data_line1_i,
                        flash_data_line0_i, flash_chip_select_n_i, flash_serial_clock_i};
            in_sync <= in_meta;
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sck_prev <= 1'b0;
        end else begin
            sck_prev <= in_sync[SY_SCK];
        end
    end

    assign sck_rise = in_sync[SY_SCK] & ~sck_prev;
    assign sck_fall = ~in_sync[SY_SCK] & sck_prev;
    assign cs_high  = in_sync[SY_CSN];
    assign lanes_in = in_sync[SY_D0+3:SY_D0];

    always_ff @(posedge ref_clk_i) begin
        if (load_valid_i) begin
            mem[load_addr_i] <= load_data_i;
        end
    end

    assign mem_byte = mem[read_start_address[MEM_AW-1:0]];

    // Sequence of phases; idle is left at once, later phases step on the sampled rising clock edge.
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state      <= ST_IDLE;
            edge_cnt   <= '0;
            byte_shift <= '0;
        end else if (cs_high) begin
            state    <= ST_IDLE;
            edge_cnt <= '0;
        end else begin
            case (state)
                ST_IDLE: begin
                    edge_cnt <= '0;
                    state    <= cont_mode ? ST_ADDR : ST_CMD;
                end
                ST_CMD: begin
                    if (sck_rise) begin
                        byte_shift <= {byte_shift[6:0], lanes_in[0]};
                        edge_cnt   <= edge_cnt + 3'h1;
                        if (edge_cnt == CMD_LAST_EDGE) begin
                            edge_cnt <= '0;
                            // Anything but the quad read is left to the single-line set.
                            state <= ({byte_shift[6:0], lanes_in[0]} == CMD_WORD_READ)
                                     ? ST_ADDR : ST_IGNORE;
                        end
                    end
                end
                ST_ADDR: begin
                    if (sck_rise) begin
                        edge_cnt <= edge_cnt + 3'h1;
                        if (edge_cnt == ADDR_LAST_EDGE) begin
                            edge_cnt <= '0;
                            state    <= ST_MODE;
                        end
                    end
                end
                ST_MODE: begin
                    if (sck_rise) begin
                        edge_cnt <= edge_cnt + 3'h1;
                        if (edge_cnt == MODE_LAST_EDGE) begin
                            edge_cnt <= '0;
                            state    <= ST_DUMMY;
                        end
                    end
                end
                ST_DUMMY: begin
                    if (sck_rise) begin
                        edge_cnt <= edge_cnt + 3'h1;
                        if (edge_cnt == DUMMY_LAST_EDGE) begin
                            edge_cnt <= '0;
                            state    <= ST_DATA;
                        end
                    end
                end
                ST_DATA: begin
                    state <= ST_DATA;
                end
                default: begin
                    state <= ST_IGNORE;
                end
            endcase
        end
    end

    // Address shifts in a nibble per rising edge; data moves it forward a byte at a time.
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            read_start_address <= '0;
        end else if (!cs_high && state == ST_ADDR && sck_rise) begin
            read_start_address <= {read_start_address[ADDR_W-5:0], lanes_in};
        end else if (!cs_high && state == ST_DATA && sck_fall && low_nibble) begin
            read_start_address <= read_start_address + 24'h1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            continuous_mode_bits <= '0;
            cont_mode            <= 1'b0;
        end else if (!cs_high && state == ST_MODE && sck_rise) begin
            continuous_mode_bits <= {continuous_mode_bits[3:0], lanes_in};
            if (edge_cnt == MODE_LAST_EDGE) begin
                cont_mode <= (continuous_mode_bits[3:0] == CONT_NIBBLE);
            end
        end
    end

    // Data is driven after each falling edge so it is settled for the next rising one.
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lane_out   <= '0;
            lane_oe    <= 1'b0;
            low_nibble <= 1'b0;
        end else if (cs_high || state != ST_DATA) begin
            lane_oe    <= 1'b0;
            low_nibble <= 1'b0;
        end else if (sck_fall) begin
            lane_oe    <= 1'b1;
            lane_out   <= low_nibble ? mem_byte[3:0] : mem_byte[7:4];
            low_nibble <= ~low_nibble;
        end
    end

    assign flash_data_line0_o    = lane_out[0];
    assign flash_data_line1_o    = lane_out[1];
    assign flash_data_line2_o    = lane_out[2];
    assign flash_data_line3_o    = lane_out[3];
    assign flash_data_line0_oe_o = lane_oe;
    assign flash_data_line1_oe_o = lane_oe;
    assign flash_data_line2_oe_o = lane_oe;
    assign flash_data_line3_oe_o = lane_oe;
    assign continuous_mode_o     = cont_mode;

    default clocking dc @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);

    chk_cmd_to_addr: assert property (
        (state == ST_CMD && !cs_high && sck_rise && edge_cnt == CMD_LAST_EDGE
         && {byte_shift[6:0], lanes_in[0]} == CMD_WORD_READ) |=> state == ST_ADDR)
        else $error("E7H command did not enter address phase");
    chk_addr_six_edges: assert property (
        (state == ST_ADDR && !cs_high && sck_rise && edge_cnt == ADDR_LAST_EDGE)
        |=> state == ST_MODE && edge_cnt == 3'h0)
        else $error("Address phase length wrong");
    chk_mode_then_dummy: assert property (
        (state == ST_MODE && !cs_high && sck_rise && edge_cnt == MODE_LAST_EDGE)
        |=> state == ST_DUMMY)
        else $error("Mode phase not followed by dummy");
    chk_dummy_then_data: assert property (
        (state == ST_DUMMY && !cs_high && sck_rise && edge_cnt == DUMMY_LAST_EDGE)
        |=> state == ST_DATA ##1 !lane_oe)
        else $error("Dummy phase wrong length or early drive");
    chk_cont_set: assert property (
        (state == ST_MODE && !cs_high && sck_rise && edge_cnt == MODE_LAST_EDGE
         && continuous_mode_bits[3:0] == CONT_NIBBLE) |=> cont_mode)
        else $error("Continuous mode not set");
    chk_cont_clear: assert property (
        (state == ST_MODE && !cs_high && sck_rise && edge_cnt == MODE_LAST_EDGE
         && continuous_mode_bits[3:0] != CONT_NIBBLE) |=> !cont_mode)
        else $error("Continuous mode not cleared");
    chk_cont_skip: assert property (
        (state == ST_IDLE && !cs_high && cont_mode) |=> state == ST_ADDR)
        else $error("Command code not skipped");
    chk_drive_only_data: assert property (
        lane_oe |-> state == ST_DATA && !$past(cs_high))
        else $error("Lanes driven outside data phase");
    chk_addr_advance: assert property (
        (state == ST_DATA && !cs_high && sck_fall && low_nibble)
        |=> read_start_address == $past(read_start_address) + 24'h1)
        else $error("Read address did not advance");
    chk_select_ends: assert property (
        cs_high |=> state == ST_IDLE ##1 !lane_oe)
        else $error("Select high did not end transfer");

    cov_data_phase: cover property (state == ST_DUMMY ##1 state == ST_DATA);
    cov_cont_read: cover property (state == ST_IDLE && !cs_high && cont_mode);
    cov_other_cmd: cover property (state == ST_CMD ##1 state == ST_IGNORE);
endmodule

// [tb/qfr_ctrl_model.sv]
// Purpose: Behavioural read controller that faces the responder's link pins.
// Assumes: Serial clock idles low and runs at 64 ns only inside frames.
// Notes: Released lanes show the inverse of the last driven nibble.
`timescale 1ns/10ps
module qfr_ctrl_model (
    input  wire logic [3:0] lane_i,
    output logic            csn_o,
    output logic            sck_o,
    output logic [3:0]      lane_o
);
    logic [3:0] drive;
    logic [3:0] last;
    logic [3:0] smp;
    logic       drv_en;
    logic [7:0] got [0:7];

    assign lane_o = drv_en ? drive : ~last;

    initial begin
        csn_o  = 1'b1;
        sck_o  = 1'b0;
        drive  = 4'h0;
        last   = 4'h0;
        drv_en = 1'b0;
    end

    // One serial clock: set lanes while low, sample the responder late in the high phase.
    task automatic tick(input logic [3:0] d, input logic en);
        sck_o  = 1'b0;
        drive  = d;
        drv_en = en;
        if (en) last = d;
        #32;
        sck_o = 1'b1;
        #30;
        smp = lane_i;
        #2;
    endtask

    task automatic read(input logic cmd, input logic [7:0] opc, input logic [23:0] a,
                        input logic [7:0] m, input int n);
        logic [3:0] hi;
        csn_o = 1'b0;
        #40;
        if (cmd) for (int i = 7; i >= 0; i--) tick({3'h7, opc[i]}, 1'b1);
        for (int i = 5; i >= 0; i--) tick(a[i*4+:4], 1'b1);
        tick(m[7:4], 1'b1);
        tick(m[3:0], 1'b1);
        tick(4'h0, 1'b0);
        tick(4'h0, 1'b0);
        for (int j = 0; j < n; j++) begin
            tick(4'h0, 1'b0);
            hi = smp;
            tick(4'h0, 1'b0);
            got[j] = {hi, smp};
        end
        sck_o = 1'b0;
        #32;
        csn_o = 1'b1;
        #64;
    endtask
endmodule

// [tb/tb_top.sv]
// Purpose: Self-checking bench for the quad-lane word fast read responder.
// Assumes: Memory is filled through the load port before any read.
// Notes: Lane levels are resolved here from the responder's enables over the model's output.
`timescale 1ns/10ps
module tb_top;
    import qfr_pkg::*;
    logic              ref_clk_i;
    logic              arst_n_i;
    logic              load_valid_i;
    logic [MEM_AW-1:0] load_addr_i;
    logic [7:0]        load_data_i;
    logic              cont;
    logic              csn;
    logic              sck;
    int                oe_cycles;
    logic [3:0]        mdl;
    logic [3:0]        dout;
    logic [3:0]        oe;
    logic [3:0]        lane;
    int                bad_count;
    int                n_checks;

    assign lane = (oe & dout) | (~oe & mdl);

    qfr_flash_reader u_qfr_flash_reader (
        .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .flash_chip_select_n_i(csn),
        .flash_serial_clock_i(sck), .flash_data_line0_i(lane[0]),
        .flash_data_line1_i(lane[1]), .flash_data_line2_i(lane[2]),
        .flash_data_line3_i(lane[3]), .flash_data_line0_o(dout[0]),
        .flash_data_line1_o(dout[1]), .flash_data_line2_o(dout[2]),
        .flash_data_line3_o(dout[3]), .flash_data_line0_oe_o(oe[0]),
        .flash_data_line1_oe_o(oe[1]), .flash_data_line2_oe_o(oe[2]),
        .flash_data_line3_oe_o(oe[3]), .load_valid_i(load_valid_i),
        .load_addr_i(load_addr_i), .load_data_i(load_data_i), .continuous_mode_o(cont));

    qfr_ctrl_model u_qfr_ctrl_model (.lane_i(lane), .csn_o(csn), .sck_o(sck), .lane_o(mdl));

    function automatic logic [7:0] exp_byte(input int a);
        return 8'((a % 1024) * 29 + (a % 1024) / 256);
    endfunction

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        if (bad_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic rd(input logic c, input logic [7:0] o, input logic [23:0] a,
                      input logic [7:0] m, input int n);
        u_qfr_ctrl_model.read(c, o, a, m, n);
        for (int j = 0; j < n; j++) begin
            check("read_byte", u_qfr_ctrl_model.got[j], exp_byte(int'(a[9:0]) + j));
        end
        check("lanes_released", {4'h0, oe}, 8'h00);
    endtask

    task automatic sc_load();
        for (int a = 0; a < MEM_DEPTH; a++) begin
            @(posedge ref_clk_i);
            #1;
            load_valid_i = 1'b1;
            load_addr_i  = MEM_AW'(a);
            load_data_i  = exp_byte(a);
        end
        @(posedge ref_clk_i);
        #1;
        load_valid_i = 1'b0;
    endtask

    task automatic sc_normal();
        rd(1'b1, CMD_WORD_READ, 24'h000004, 8'h5a, 4);
        check("cont_after_5a", {7'h0, cont}, 8'h00);
    endtask

    task automatic sc_continuous();
        rd(1'b1, CMD_WORD_READ, 24'h000010, 8'ha5, 2);
        check("cont_after_a5", {7'h0, cont}, 8'h01);
        rd(1'b0, 8'h00, 24'h000020, 8'h3c, 2);
        check("cont_after_3c", {7'h0, cont}, 8'h00);
        rd(1'b1, CMD_WORD_READ, 24'hfff3fe, 8'hf0, 3);
    endtask

    // A foreign opcode must leave the lanes untouched and the mode flag clear.
    task automatic sc_refused();
        int oe_before;
        oe_before = oe_cycles;
        u_qfr_ctrl_model.read(1'b1, 8'h0b, 24'h000000, 8'ha0, 2);
        check("oe_on_foreign_cmd", 8'(oe_cycles - oe_before), 8'h00);
        check("cont_on_foreign_cmd", {7'h0, cont}, 8'h00);
    endtask

    // Any even start is accepted, not only multiples of four.
    task automatic sc_odd();
        rd(1'b1, CMD_WORD_READ, 24'h0002a2, 8'h00, 2);
    endtask

    always @(posedge ref_clk_i) begin
        if (|oe) oe_cycles <= oe_cycles + 1;
        if (u_qfr_ctrl_model.drv_en === 1'b1 && oe !== 4'h0) begin
            check("lane_contention", {4'h0, oe}, 8'h00);
        end
    end

    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end

    initial begin
        #200000;
        bad_count++;
        stop_test();
    end

    initial begin
        arst_n_i     = 1'b0;
        load_valid_i = 1'b0;
        load_addr_i  = '0;
        load_data_i  = 8'h00;
        repeat (2) @(posedge ref_clk_i);
        #1;
        arst_n_i = 1'b1;
        sc_load();
        sc_normal();
        sc_continuous();
        sc_refused();
        sc_odd();
        stop_test();
    end
endmodule
